/* logic/tpc_params.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH
`define TPC_ADDR_W 8
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_LCTRL 8'h04
`define TPC_OFF_PERIOD 8'h08
`define TPC_OFF_WIDTH 8'h0C
`define TPC_OFF_STATUS 8'h10
`define TPC_OFF_MASK 8'h14
`define TPC_OFF_COUNT 8'h18
`define TPC_OFF_DIV 8'h1C
`define TPC_BIT_PRESET 7
`define TPC_BIT_RUN 3
`define TPC_MODE_LSB 0
`define TPC_BIT_MATCH 0
`define TPC_RST_CTRL 5'h00
`define TPC_RST_PERIOD 16'hFFFF
`define TPC_RST_WIDTH 16'h0000
`define TPC_RST_DIV 16'h0000
`define TPC_CLK_MHZ 250
`define TPC_CLK_PERIOD_NS 4
`define TPC_WARM_LOW_MIN 16'h0100
`define TPC_WARM_HIGH_MAX 16'hFF00
`endif

/* logic/tpc_pkg.sv */
// Types shared by the cascaded pulse and warm-up timer.
package tpc_pkg;
    typedef enum logic [2:0] {
        TPC_MODE_OFF = 3'b000,
        TPC_MODE_WARM = 3'b101,
        TPC_MODE_PULSE = 3'b111
    } tpc_mode_e;

    // Upper timer control fields as software sees them.
    typedef struct packed {
        logic preset;
        logic run;
        logic [2:0] mode;
    } tpc_ctrl_s;

    // APB request bundle from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tpc_apb_req_s;
endpackage

/* logic/tpc_prescale.sv */
// Source clock divider that turns clk_in into a one-cycle count enable.
`timescale 1ns/1ps
`default_nettype none
module tpc_prescale #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic run_in,
    input wire logic [W-1:0] div_in,
    output logic tick_out
);
    logic [W-1:0] cnt;
    wire wrap = (cnt >= div_in);

    // A stopped timer restarts its divider so the first tick is a full one.
    always_ff @(posedge clk_in) begin
        if (!resetn_in || !run_in) begin
            cnt <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + 1'b1;
            tick_out <= wrap;
        end
    end
endmodule
`default_nettype wire

/* logic/tpc_timer.sv */
// Cascaded 16-bit pulse generator and warm-up counter with APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"
module tpc_timer #(
    parameter int CW = 16,
    parameter int DW = 16
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire tpc_pkg::tpc_apb_req_s apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic pulse_out_pin_out,
    output logic period_match_irq_out,
    output logic irq_out
);
    import tpc_pkg::*;

    tpc_ctrl_s ctrl;
    logic lower_flop_preset;
    logic [CW-1:0] period;
    logic [CW-1:0] width;
    logic [DW-1:0] div;
    logic status;
    logic mask;
    logic [CW-1:0] count;
    logic output_toggle_flop;
    logic tick;

    // Register decode of the APB access phase.
    wire acc = apb_in.psel && apb_in.penable;
    wire take = acc && pready_out;
    wire wr = take && apb_in.pwrite;
    wire [7:0] addr = apb_in.paddr;
    wire [31:0] wd = apb_in.pwdata;
    wire hit_ctrl = (addr == `TPC_OFF_CTRL);
    wire hit_lctrl = (addr == `TPC_OFF_LCTRL);
    wire hit_period = (addr == `TPC_OFF_PERIOD);
    wire hit_width = (addr == `TPC_OFF_WIDTH);
    wire hit_status = (addr == `TPC_OFF_STATUS);
    wire hit_mask = (addr == `TPC_OFF_MASK);
    wire hit_count = (addr == `TPC_OFF_COUNT);
    wire hit_div = (addr == `TPC_OFF_DIV);
    wire mapped = hit_ctrl | hit_lctrl | hit_period | hit_width |
                  hit_status | hit_mask | hit_count | hit_div;
    wire wr_ctrl = wr && hit_ctrl;
    wire new_run = wd[`TPC_BIT_RUN];
    wire new_preset = wd[`TPC_BIT_PRESET];

    // Mode decode and compare against the live registers.
    wire is_pulse = (ctrl.mode == TPC_MODE_PULSE);
    wire is_warm = (ctrl.mode == TPC_MODE_WARM);
    wire active = ctrl.run && (is_pulse || is_warm);
    wire step = active && tick;
    // Matches look at the value the count steps to, so a setting of N
    // spans N source ticks and the cleared state adds no extra tick.
    wire [CW-1:0] count_up = count + 1'b1;
    wire [CW-1:0] warm_target = {period[CW-1:8], 8'h00};
    wire width_hit = is_pulse && (count_up == width);
    wire pulse_period_hit = is_pulse && (count_up == period);
    wire warm_hit = is_warm && (count_up == warm_target);
    wire period_hit = step && (pulse_period_hit || warm_hit);
    wire flop_flip = step && is_pulse && (width_hit || pulse_period_hit);
    wire start = wr_ctrl && !ctrl.run && new_run;
    // Preset loads only from a write issued while already stopped, so the
    // write that stops the timer never disturbs the held pin level.
    wire preset_load = wr_ctrl && !ctrl.run;

    logic [CW-1:0] next_count;
    logic next_flop;
    logic next_status;
    logic [31:0] next_rdata;

    // Counter: cleared on start and on a period match, frozen when stopped.
    always_comb begin
        next_count = count;
        if (start) begin
            next_count = '0;
        end else if (period_hit) begin
            next_count = '0;
        end else if (step) begin
            next_count = count_up;
        end
    end

    // Output flop: software preset when stopped, toggles on pulse-mode matches.
    // Width and period matches are ORed, so a width equal to period toggles once.
    always_comb begin
        next_flop = output_toggle_flop;
        if (preset_load) begin
            next_flop = new_preset;
        end else if (flop_flip) begin
            next_flop = !output_toggle_flop;
        end
    end

    // Sticky match flag; a new match beats a clear in the same cycle.
    always_comb begin
        next_status = status;
        if (wr && hit_status && wd[`TPC_BIT_MATCH]) begin
            next_status = 1'b0;
        end
        if (period_hit) begin
            next_status = 1'b1;
        end
    end

    // Read data mux; unmapped addresses read as zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            hit_ctrl: next_rdata = {24'h0, ctrl.preset, 3'b000, ctrl.run,
                                    ctrl.mode};
            hit_lctrl: next_rdata = {24'h0, lower_flop_preset, 7'h00};
            hit_period: next_rdata = {16'h0, period};
            hit_width: next_rdata = {16'h0, width};
            hit_status: next_rdata = {31'h0, status};
            hit_mask: next_rdata = {31'h0, mask};
            hit_count: next_rdata = {16'h0, count};
            hit_div: next_rdata = {16'h0, div};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait state, so read data comes straight from a flop.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= acc && !pready_out;
            pslverr_out <= acc && !pready_out && !mapped;
            prdata_out <= next_rdata;
        end
    end

    // Software-visible configuration registers.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ctrl <= `TPC_RST_CTRL;
            lower_flop_preset <= 1'b0;
            period <= `TPC_RST_PERIOD;
            width <= `TPC_RST_WIDTH;
            div <= `TPC_RST_DIV;
            mask <= 1'b0;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl <= {new_preset, new_run, wd[2:0]};
            end
            if (hit_lctrl) begin
                lower_flop_preset <= wd[`TPC_BIT_PRESET];
            end
            if (hit_period) begin
                period <= wd[CW-1:0];
            end
            if (hit_width) begin
                width <= wd[CW-1:0];
            end
            if (hit_div) begin
                div <= wd[DW-1:0];
            end
            if (hit_mask) begin
                mask <= wd[`TPC_BIT_MATCH];
            end
        end
    end

    // Timer state and registered outputs.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            count <= '0;
            status <= 1'b0;
            output_toggle_flop <= 1'b0;
            pulse_out_pin_out <= 1'b1;
            period_match_irq_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            count <= next_count;
            status <= next_status;
            output_toggle_flop <= next_flop;
            pulse_out_pin_out <= !next_flop;
            period_match_irq_out <= period_hit;
            irq_out <= status && mask;
        end
    end

    // Source clock; its ratio sets the warm-up times for each oscillator.
    tpc_prescale #(
        .W(DW)
    ) u_prescale (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .run_in(active),
        .div_in(div),
        .tick_out(tick)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_width_toggle;
        step && width_hit && !pulse_period_hit && !preset_load
            |=> output_toggle_flop != $past(output_toggle_flop);
    endproperty
    a_width_toggle: assert property (p_width_toggle)
        else $error("width match did not toggle the flop");

    property p_period_clear;
        step && pulse_period_hit && !start && !preset_load
            |=> count == 0 && output_toggle_flop != $past(output_toggle_flop)
                && period_match_irq_out;
    endproperty
    a_period_clear: assert property (p_period_clear)
        else $error("period match did not clear, toggle and interrupt");

    property p_pin_inverse;
        pulse_out_pin_out == !output_toggle_flop;
    endproperty
    a_pin_inverse: assert property (p_pin_inverse)
        else $error("pulse pin is not the inverse of the flop");

    property p_reset_flop;
        @(posedge clk_in) disable iff (1'b0)
            !resetn_in |=> !output_toggle_flop && pulse_out_pin_out;
    endproperty
    a_reset_flop: assert property (p_reset_flop)
        else $error("reset did not clear the flop");

    property p_warm_match;
        step && is_warm && CW'(count + 1'b1) == {period[CW-1:8], 8'h00}
            |=> count == 0 && status && period_match_irq_out;
    endproperty
    a_warm_match: assert property (p_warm_match)
        else $error("warm-up match on upper byte missed");

    property p_warm_flop;
        is_warm && !preset_load |=> $stable(output_toggle_flop);
    endproperty
    a_warm_flop: assert property (p_warm_flop)
        else $error("flop moved in warm-up mode");

    property p_irq_pulse;
        period_match_irq_out |=> !period_match_irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("period match pulse longer than one cycle");

    property p_stop_freeze;
        !ctrl.run && !start |=> $stable(count);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze)
        else $error("counter moved while stopped");

    property p_stop_hold;
        $fell(ctrl.run) |=> $stable(pulse_out_pin_out);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("pin changed on the stopping write");

    property p_preset_clear;
        wr_ctrl && !ctrl.run && !new_preset
            |=> !output_toggle_flop && pulse_out_pin_out;
    endproperty
    a_preset_clear: assert property (p_preset_clear)
        else $error("cleared preset did not drive pin high");

    property p_irq_level;
        1'b1 |=> irq_out == $past(status && mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt does not follow unmasked status");

    // A match in the same cycle as a clear must leave the flag set.
    property p_set_wins;
        period_hit && wr && hit_status && wd[`TPC_BIT_MATCH] |=> status;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("status clear beat a new match");

    c_pulse_period: cover property (step && pulse_period_hit);
    c_width_hit: cover property (step && width_hit);
    c_warm_hit: cover property (step && warm_hit);
    c_set_and_clear: cover property (period_hit && wr && hit_status);
endmodule
`default_nettype wire

/* dv/tpc_pin_load.sv */
// Load on the pulse pin that measures how long the pin stays low.
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_load #(
    parameter logic LATCH = 1'h1
) (
    input wire logic clk_in,
    input wire logic pin_in,
    output var logic [15:0] low_len_out
);
    logic [15:0] run_len = 16'h0000;
    // The shared port latch gates the pin, so it must stay at one.
    wire logic level = pin_in & LATCH;
    // Count low clocks and publish the length when the pin rises again.
    always_ff @(posedge clk_in) begin
        run_len <= level ? 16'h0000 : run_len + 16'h0001;
        if (level && run_len != 16'h0000) begin
            low_len_out <= run_len;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_tpc_timer.sv */
// Self-checking bench for the cascaded pulse and warm-up timer.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"
module tb_tpc_timer;
    import tpc_pkg::*;
    logic clk_in = 1'h0;
    logic resetn_in = 1'h0;
    tpc_apb_req_s apb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic match;
    logic irq;
    logic [15:0] low_len;
    logic [31:0] rd;
    logic err;
    logic held;
    int error_cnt = 0;
    int checks = 0;
    int gap;

    // Device under test and the load on its pulse pin.
    tpc_timer i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .apb_in(apb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pulse_out_pin_out(pin), .period_match_irq_out(match),
        .irq_out(irq));
    tpc_pin_load i_load (.clk_in(clk_in), .pin_in(pin),
        .low_len_out(low_len));

    // Free-running 250 MHz clock.
    always #2 clk_in = ~clk_in;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_in);
        apb <= '{1'h1, 1'h0, wr, a, d};
        @(posedge clk_in);
        apb.penable <= 1'h1;
        // Only the watchdog ends this wait.
        do begin
            @(posedge clk_in);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        apb <= '0;
    endtask

    // Clocks until the next period-match pulse, bounded.
    task automatic wait_match(output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (match !== 1'h1 && n < 2000);
    endtask

    task automatic t_reset();
        chk(32'(pin), 32'h1);
        bus(1'h0, `TPC_OFF_PERIOD, 32'h0);
        chk(rd, 32'h0000FFFF);
        bus(1'h0, 8'h20, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        bus(1'h1, `TPC_OFF_LCTRL, 32'h80);
        bus(1'h0, `TPC_OFF_LCTRL, 32'h0);
        chk(rd, 32'h00000080);
        $display("TB: reset test done");
    endtask

    // Divider 1 gives a tick every two clocks: period 18, low 12.
    task automatic t_pulse();
        bus(1'h1, `TPC_OFF_DIV, 32'h1);
        bus(1'h1, `TPC_OFF_WIDTH, 32'h3);
        bus(1'h1, `TPC_OFF_PERIOD, 32'h9);
        bus(1'h1, `TPC_OFF_MASK, 32'h1);
        bus(1'h1, `TPC_OFF_CTRL, 32'h0F);
        wait_match(gap);
        wait_match(gap);
        chk(32'(gap), 32'h12);
        @(negedge clk_in);
        chk(32'(match), 32'h0);
        chk(32'(irq), 32'h1);
        chk(32'(low_len), 32'hC);
        bus(1'h1, `TPC_OFF_CTRL, 32'h07);
        @(negedge clk_in);
        held = pin;
        repeat (30) @(negedge clk_in);
        chk(32'(pin), 32'(held));
        bus(1'h0, `TPC_OFF_COUNT, 32'h0);
        gap = int'(rd);
        bus(1'h0, `TPC_OFF_COUNT, 32'h0);
        chk(rd, 32'(gap));
        bus(1'h1, `TPC_OFF_MASK, 32'h0);
        repeat (2) @(negedge clk_in);
        chk(32'(irq), 32'h0);
        bus(1'h1, `TPC_OFF_MASK, 32'h1);
        repeat (2) @(negedge clk_in);
        chk(32'(irq), 32'h1);
        bus(1'h1, `TPC_OFF_STATUS, 32'h1);
        repeat (2) @(negedge clk_in);
        chk(32'(irq), 32'h0);
        $display("TB: pulse test done");
    endtask

    // Preset one inverts the waveform: the pin is low for 6 clocks.
    task automatic t_preset();
        bus(1'h1, `TPC_OFF_CTRL, 32'h07);
        repeat (3) @(negedge clk_in);
        chk(32'(pin), 32'h1);
        bus(1'h1, `TPC_OFF_CTRL, 32'h87);
        repeat (3) @(negedge clk_in);
        chk(32'(pin), 32'h0);
        bus(1'h1, `TPC_OFF_CTRL, 32'h8F);
        wait_match(gap);
        wait_match(gap);
        chk(32'(low_len), 32'h6);
        bus(1'h1, `TPC_OFF_CTRL, 32'h87);
        bus(1'h1, `TPC_OFF_CTRL, 32'h07);
        $display("TB: preset test done");
    endtask

    // Only the upper period byte counts: 0x0100 gives 256 clocks.
    task automatic t_warm();
        bus(1'h1, `TPC_OFF_DIV, 32'h0);
        bus(1'h1, `TPC_OFF_PERIOD, 32'h01A5);
        bus(1'h1, `TPC_OFF_CTRL, 32'h0D);
        wait_match(gap);
        wait_match(gap);
        chk(32'(gap), 32'h100);
        chk(32'(pin), 32'h1);
        bus(1'h1, `TPC_OFF_CTRL, 32'h05);
        $display("TB: warm-up test done");
    endtask

    task automatic test_done();
        $display("TB: checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Reset for six cycles, then run every scenario in turn.
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'h1;
        t_reset();
        t_pulse();
        t_preset();
        t_warm();
        test_done();
    end

    // Watchdog: the whole run needs well under 5000 clocks.
    initial begin
        #80000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
